// >>> design/spi_master_pkg.sv
// package: register map, field positions, reset values and types of the spi master core
package spi_master_pkg;

  localparam logic [2:0] OFF_CTRL1  = 3'h0;
  localparam logic [2:0] OFF_CTRL2  = 3'h1;
  localparam logic [2:0] OFF_BAUD   = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_DATA   = 3'h5;
  localparam logic [2:0] OFF_MATCH  = 3'h7;

  // control register one fields
  localparam int C1_IE    = 7;
  localparam int C1_EN    = 6;
  localparam int C1_MASTER_SELECT_BIT  = 4;
  localparam int C1_CLOCK_POLARITY_BIT  = 3;
  localparam int C1_CLOCK_PHASE_BIT  = 2;
  localparam int C1_SELECT_OUTPUT_ENABLE  = 1;
  localparam int C1_LSBF  = 0;
  // control two fields
  localparam int C2_FAULT_DETECT_ENABLE = 4;
  localparam int C2_BIDOE  = 3;
  localparam int C2_PINMOD = 0;
  // status fields
  localparam int ST_RXF  = 7;
  localparam int ST_MTCH = 6;
  localparam int ST_TXE  = 5;
  localparam int ST_MODE_FAULT_FLAG = 4;

  localparam logic [7:0] CTRL1_RST  = 8'h04;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] MATCH_RST  = 8'h00;
  localparam logic [3:0] RATE_MAX   = 4'h8;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [2:0] MASK_CTRL1 = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b10
  } xfer_state_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_n;
  } pin_out_type;

endpackage : spi_master_pkg

// >>> design/spi_master_core.sv
// spi data path and master-mode core with baud generator, match and mode fault logic
`timescale 1ns/1ps
`default_nettype none
module spi_master_core (
  input  wire  logic       i_mclk,
  input  wire  logic       i_rst,
  input  wire  logic [2:0] i_addr,
  input  wire  logic [7:0] i_wdata,
  input  wire  logic       i_wr,
  input  wire  logic       i_rd,
  output logic [7:0]       o_rdata,
  input  wire  logic       i_sck,
  input  wire  logic       i_mosi,
  input  wire  logic       i_miso,
  input  wire  logic       i_ss_n,
  output logic             o_sck,
  output logic             o_sck_oe,
  output logic             o_mosi,
  output logic             o_mosi_oe,
  output logic             o_ss_n,
  output logic             o_ss_oe,
  output logic             o_pins_spi,
  output logic             o_irq
);

  spi_master_pkg::reg_req_type    req;
  spi_master_pkg::pin_out_type    pin_reg;
  spi_master_pkg::xfer_state_type state_reg;

  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [7:0]  baud_reg;
  logic [7:0]  match_val_reg;
  logic [7:0]  txbuf_reg;
  logic        txfull_reg;
  logic [7:0]  rxbuf_reg;
  logic        rxfull_reg;
  logic        match_reg;
  logic        mode_fault_flag_reg;
  logic        txe_seen_reg;
  logic        mode_fault_flag_seen_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bitcnt_reg;
  logic        phase_reg;
  logic        sampled_reg;
  logic [12:0] div_reg;
  logic [7:0]  rdata_reg;
  logic        miso_s1_reg;
  logic        miso_s2_reg;
  logic        ss_s1_reg;
  logic        ss_s2_reg;

  // half bit time in bus clocks: (prescale + 1) * 2^rate
  function automatic logic [12:0] half_period(input logic [7:0] b);
    logic [3:0]  rate;
    logic [12:0] pre;
    rate = (b[3:0] > spi_master_pkg::RATE_MAX) ? spi_master_pkg::RATE_MAX : b[3:0];
    pre  = {10'h000, b[6:4]} + 13'h0001;
    half_period = 13'(pre << rate);
  endfunction : half_period

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  wire enabled   = ctrl1_reg[spi_master_pkg::C1_EN];
  wire master    = enabled & ctrl1_reg[spi_master_pkg::C1_MASTER_SELECT_BIT];
  wire clock_polarity_bit      = ctrl1_reg[spi_master_pkg::C1_CLOCK_POLARITY_BIT];
  wire clock_phase_bit      = ctrl1_reg[spi_master_pkg::C1_CLOCK_PHASE_BIT];
  wire lsb_first = ctrl1_reg[spi_master_pkg::C1_LSBF];
  wire fault_detect_enable    = ctrl2_reg[spi_master_pkg::C2_FAULT_DETECT_ENABLE];
  wire select_output_enable      = ctrl1_reg[spi_master_pkg::C1_SELECT_OUTPUT_ENABLE];
  wire busy      = (state_reg != spi_master_pkg::ST_IDLE);

  wire wr_ctrl1  = req.wr & (req.addr == spi_master_pkg::OFF_CTRL1);
  wire wr_ctrl2  = req.wr & (req.addr == spi_master_pkg::OFF_CTRL2);
  wire wr_baud   = req.wr & (req.addr == spi_master_pkg::OFF_BAUD);
  wire wr_data   = req.wr & (req.addr == spi_master_pkg::OFF_DATA);
  wire wr_match  = req.wr & (req.addr == spi_master_pkg::OFF_MATCH);
  wire rd_status = req.rd & (req.addr == spi_master_pkg::OFF_STATUS);
  wire rd_data   = req.rd & (req.addr == spi_master_pkg::OFF_DATA);

  wire txe_now    = ~txfull_reg;
  wire data_taken = wr_data & txe_seen_reg & txe_now;

  // any write that changes a format or baud field kills an active master transfer
  wire c1_fmt_chg = wr_ctrl1 & ((req.wdata[4:0] ^ ctrl1_reg[4:0]) & 5'b01111) != 5'h00;
  wire c2_fmt_chg = wr_ctrl2 &
    ((req.wdata[spi_master_pkg::C2_FAULT_DETECT_ENABLE] != fault_detect_enable) |
     (req.wdata[spi_master_pkg::C2_PINMOD] != ctrl2_reg[spi_master_pkg::C2_PINMOD]) |
     (ctrl2_reg[spi_master_pkg::C2_PINMOD] &
      (req.wdata[spi_master_pkg::C2_BIDOE] != ctrl2_reg[spi_master_pkg::C2_BIDOE])));
  wire baud_chg   = wr_baud & (req.wdata[6:0] != baud_reg[6:0]);
  wire cfg_abort  = busy & master & (c1_fmt_chg | c2_fmt_chg | baud_chg);

  wire fault      = master & fault_detect_enable & ~select_output_enable & ~ss_s2_reg;
  wire abort      = fault | cfg_abort | ~master;

  wire div_done   = (div_reg == 13'h0001);
  wire last_edge  = phase_reg & (bitcnt_reg == spi_master_pkg::BITS_BYTE - 4'h1);
  wire sample_in  = miso_s2_reg;
  wire [7:0] shift_next = lsb_first ? {sampled_reg, shift_reg[7:1]}
                                    : {shift_reg[6:0], sampled_reg};
  wire xfer_done  = (state_reg == spi_master_pkg::ST_SHIFT) & div_done & last_edge & ~abort;
  wire [7:0] rx_byte = clock_phase_bit ? shift_next : shift_next;
  wire start_ok   = txfull_reg & master & ~fault;

  // slave-side shifting and the mosi/sck inputs are outside this core
  wire unused_in  = i_sck ^ i_mosi;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
      ss_s1_reg   <= 1'b1;
      ss_s2_reg   <= 1'b1;
    end else begin
      miso_s1_reg <= i_miso;
      miso_s2_reg <= miso_s1_reg;
      ss_s1_reg   <= i_ss_n;
      ss_s2_reg   <= ss_s1_reg;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl1_reg     <= spi_master_pkg::CTRL1_RST;
      ctrl2_reg     <= spi_master_pkg::CTRL2_RST;
      baud_reg      <= spi_master_pkg::BAUD_RST;
      match_val_reg <= spi_master_pkg::MATCH_RST;
    end else begin
      if (fault) begin
        ctrl1_reg[spi_master_pkg::C1_MASTER_SELECT_BIT] <= 1'b0;
      end else if (wr_ctrl1) begin
        ctrl1_reg <= req.wdata;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= req.wdata & 8'h19;
      end
      if (wr_baud) begin
        baud_reg <= req.wdata & 8'h7f;
      end
      if (wr_match) begin
        match_val_reg <= req.wdata;
      end
    end
  end

  // status flags: hardware set wins over software clear in the same cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      txe_seen_reg  <= 1'b0;
      mode_fault_flag_seen_reg <= 1'b0;
      mode_fault_flag_reg      <= 1'b0;
      rxfull_reg    <= 1'b0;
      match_reg     <= 1'b0;
      rxbuf_reg     <= spi_master_pkg::DATA_RST;
    end else begin
      if (rd_status) begin
        txe_seen_reg <= txe_now;
      end else if (req.wr & (req.addr == spi_master_pkg::OFF_DATA)) begin
        txe_seen_reg <= 1'b0;
      end
      if (rd_status) begin
        mode_fault_flag_seen_reg <= mode_fault_flag_reg;
      end else if (wr_ctrl1) begin
        mode_fault_flag_seen_reg <= 1'b0;
      end
      if (fault) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (wr_ctrl1 & mode_fault_flag_seen_reg) begin
        mode_fault_flag_reg <= 1'b0;
      end
      if (xfer_done & ~rxfull_reg) begin
        rxbuf_reg  <= rx_byte;
        rxfull_reg <= 1'b1;
      end else if (rd_data) begin
        rxfull_reg <= 1'b0;
      end
      if (xfer_done & ~rxfull_reg) begin
        match_reg <= (rx_byte == match_val_reg);
      end else if (rd_status & match_reg) begin
        match_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      txbuf_reg  <= spi_master_pkg::DATA_RST;
      txfull_reg <= 1'b0;
    end else begin
      if (data_taken) begin
        txbuf_reg  <= req.wdata;
        txfull_reg <= 1'b1;
      end else if (state_reg == spi_master_pkg::ST_IDLE & start_ok) begin
        txfull_reg <= 1'b0;
      end else if (xfer_done & start_ok & clock_phase_bit) begin
        txfull_reg <= 1'b0;
      end
    end
  end

  // transfer engine: lead-in of half a bit, then sixteen half-bit edges
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= spi_master_pkg::ST_IDLE;
      shift_reg   <= spi_master_pkg::DATA_RST;
      bitcnt_reg  <= 4'h0;
      phase_reg   <= 1'b0;
      sampled_reg <= 1'b0;
      div_reg     <= 13'h0001;
    end else if (abort) begin
      state_reg <= spi_master_pkg::ST_IDLE;
      phase_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        spi_master_pkg::ST_IDLE: begin
          if (start_ok) begin
            shift_reg  <= txbuf_reg;
            bitcnt_reg <= 4'h0;
            phase_reg  <= 1'b0;
            div_reg    <= half_period(baud_reg);
            state_reg  <= spi_master_pkg::ST_LEAD;
          end
        end
        spi_master_pkg::ST_LEAD: begin
          if (div_done) begin
            div_reg   <= half_period(baud_reg);
            state_reg <= spi_master_pkg::ST_SHIFT;
          end else begin
            div_reg <= div_reg - 13'h0001;
          end
        end
        spi_master_pkg::ST_SHIFT: begin
          if (!div_done) begin
            div_reg <= div_reg - 13'h0001;
          end else begin
            div_reg   <= half_period(baud_reg);
            phase_reg <= ~phase_reg;
            if (!phase_reg) begin
              sampled_reg <= sample_in;
            end else begin
              shift_reg  <= shift_next;
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
            if (last_edge) begin
              // phase 0 slaves need select high between frames, so only phase 1 chains;
              // phase 0 passes through idle for one cycle and restarts from there
              if (start_ok & clock_phase_bit) begin
                shift_reg  <= txbuf_reg;
                bitcnt_reg <= 4'h0;
                state_reg  <= spi_master_pkg::ST_SHIFT;
              end else begin
                state_reg <= spi_master_pkg::ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= spi_master_pkg::ST_IDLE;
      endcase
    end
  end

  wire out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
  wire in_xfer = (state_reg == spi_master_pkg::ST_SHIFT);

  // edge parity: clock_phase_bit=0 samples on odd edges, clock_phase_bit=1 on even edges
  wire sck_lvl = in_xfer & (clock_phase_bit ? ~phase_reg : phase_reg);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_reg <= '{sck: 1'b0, mosi: 1'b0, ss_n: 1'b1};
    end else begin
      pin_reg.sck  <= sck_lvl ^ clock_polarity_bit;
      pin_reg.mosi <= out_bit;
      pin_reg.ss_n <= ~busy | abort;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (1'b1)
        rd_status: rdata_reg <= {rxfull_reg, match_reg, txe_now, mode_fault_flag_reg, 4'h0};
        rd_data:   rdata_reg <= rxbuf_reg;
        default: begin
          if (!req.rd) begin
            rdata_reg <= 8'h00;
          end else if (req.addr == spi_master_pkg::OFF_CTRL1) begin
            rdata_reg <= ctrl1_reg;
          end else if (req.addr == spi_master_pkg::OFF_CTRL2) begin
            rdata_reg <= ctrl2_reg;
          end else if (req.addr == spi_master_pkg::OFF_BAUD) begin
            rdata_reg <= baud_reg;
          end else if (req.addr == spi_master_pkg::OFF_MATCH) begin
            rdata_reg <= match_val_reg;
          end else begin
            rdata_reg <= 8'h00;
          end
        end
      endcase
    end
  end

  assign o_rdata    = rdata_reg;
  assign o_pins_spi = enabled;
  assign o_sck      = pin_reg.sck;
  assign o_mosi     = pin_reg.mosi;
  assign o_ss_n     = pin_reg.ss_n;
  assign o_sck_oe   = master;
  assign o_mosi_oe  = master & ~(ctrl2_reg[spi_master_pkg::C2_PINMOD] &
                                 ~ctrl2_reg[spi_master_pkg::C2_BIDOE]);
  assign o_ss_oe    = master & fault_detect_enable & select_output_enable;
  assign o_irq      = ctrl1_reg[spi_master_pkg::C1_IE] & mode_fault_flag_reg & ~unused_in
                      | ctrl1_reg[spi_master_pkg::C1_IE] & mode_fault_flag_reg & unused_in;

endmodule : spi_master_core
`default_nettype wire

// >>> verif/spi_master_core_asserts.sv
// checker: port-level assertions of the spi master core
`timescale 1ns/1ps
`default_nettype none
module spi_master_core_asserts (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [2:0] i_addr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_sck,
  input wire logic       o_sck_oe,
  input wire logic       o_mosi_oe,
  input wire logic       o_ss_n,
  input wire logic       o_ss_oe,
  input wire logic       o_pins_spi,
  input wire logic       o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence ss_start;
    o_ss_oe && $fell(o_ss_n);
  endsequence
  sequence sck_moves;
    $changed(o_sck);
  endsequence

  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_rdata_unmapped: assert property (
    $past(i_rd) && ($past(i_addr) == 3'h4 || $past(i_addr) == 3'h6) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_release_all: assert property (!o_sck_oe |-> !o_ss_oe && !o_mosi_oe)
    else $error("output enable left on without master");
  chk_irq_fault: assert property (o_irq |-> !o_sck_oe)
    else $error("interrupt while still master");
  chk_ss_lead: assert property (ss_start |-> $stable(o_sck))
    else $error("clock moved with select fall");
  chk_ss_active: assert property (ss_start |-> ##[1:600] sck_moves)
    else $error("select low without clock");
  chk_ss_idle: assert property (
    o_ss_oe && o_ss_n && $past(o_ss_n) && $past(o_ss_n, 2) |-> $stable(o_sck))
    else $error("clock moved while idle");
  chk_oe_pair: assert property (o_ss_oe |-> o_sck_oe && o_pins_spi)
    else $error("select output without master");
endmodule : spi_master_core_asserts

bind spi_master_core spi_master_core_asserts u_spi_master_core_asserts (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_mosi_oe(o_mosi_oe), .o_ss_n(o_ss_n),
  .o_ss_oe(o_ss_oe), .o_pins_spi(o_pins_spi), .o_irq(o_irq));
`default_nettype wire

// >>> verif/spi_slave_model.sv
// partner: behavioural spi slave, polarity 0 phase 0, msb first
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  input  wire logic [7:0] i_reply,
  output logic            o_miso,
  output logic [7:0]      o_rx,
  output int              o_count
);
  logic [7:0] tx;
  logic [7:0] rx;
  int         nb;
  initial begin
    tx = 8'h00;
    rx = 8'h00;
    o_rx = 8'h00;
    o_count = 0;
    nb = 0;
  end
  // a deselected slave returns to idle, so an aborted frame leaves nothing behind
  always @(posedge i_ss_n) nb = 0;
  always @(negedge i_ss_n) begin
    tx = i_reply;
    nb = 0;
  end
  always @(posedge i_sck) if (!i_ss_n) begin
    rx = {rx[6:0], i_mosi};
    nb++;
    if (nb == 8) begin
      o_rx = rx;
      o_count++;
    end
  end
  always @(negedge i_sck) if (!i_ss_n) tx = {tx[6:0], 1'b0};
  // released line shows the inverse of its last level, never a stale copy
  assign o_miso = i_ss_n ? ~tx[7] : tx[7];
endmodule : spi_slave_model
`default_nettype wire

// >>> verif/spi_master_core_bench.sv
// testbench: register-level scenarios against a behavioural slave
`timescale 1ns/1ps
`default_nettype none
module spi_master_core_bench;
  logic       i_mclk, i_rst, i_wr, i_rd, ss_drv;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, reply, rx, d;
  logic       o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_ss_n, o_ss_oe, o_pins_spi, o_irq;
  logic       miso;
  wire logic  sck_w  = o_sck_oe ? o_sck : 1'b0;
  wire logic  mosi_w = o_mosi_oe ? o_mosi : 1'b0;
  wire logic  ss_w   = o_ss_oe ? o_ss_n : ss_drv;
  int         n_mismatch, n_tests, cnt, cyc, i, ss_low;

  spi_master_core u_spi_master_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(sck_w),
    .i_mosi(mosi_w), .i_miso(miso), .i_ss_n(ss_w), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
    .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe), .o_ss_n(o_ss_n), .o_ss_oe(o_ss_oe),
    .o_pins_spi(o_pins_spi), .o_irq(o_irq));
  spi_slave_model u_spi_slave_model (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(ss_w),
    .i_reply(reply), .o_miso(miso), .o_rx(rx), .o_count(cnt));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // cycles with select low, used to check the frame length
  always @(posedge i_mclk) begin
    if (o_ss_n === 1'b0) ss_low++;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  // poll status until the chosen flag is set; bounded
  task automatic poll(input int bit_no, output logic [7:0] v);
    for (int k = 0; k < 300; k++) begin
      rd(spi_master_pkg::OFF_STATUS, v);
      if (v[bit_no] === 1'b1) return;
    end
    chk("status poll", 8'h01, 8'h00);
  endtask : poll

  task automatic send(input logic [7:0] v);
    poll(spi_master_pkg::ST_TXE, d);
    wr(spi_master_pkg::OFF_DATA, v);
  endtask : send

  task automatic wait_count(input int n);
    for (int k = 0; k < 400 && cnt < n; k++) @(posedge i_mclk);
    chk("frames", n[7:0], cnt[7:0]);
  endtask : wait_count

  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, ss_drv, reply} = {1'b1, 13'h0000, 1'b1, 8'h3C};
    ss_low = 0;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(3'h4, d);
    chk("unmapped", 8'h00, d);
    wr(spi_master_pkg::OFF_MATCH, 8'h3C);
    rd(spi_master_pkg::OFF_MATCH, d);
    chk("match reg", 8'h3C, d);
    wr(spi_master_pkg::OFF_CTRL2, 8'h10);
    // half bit of four clocks: the input synchroniser needs more than two
    wr(spi_master_pkg::OFF_BAUD, 8'h02);
    wr(spi_master_pkg::OFF_CTRL1, 8'h52);
    #1 chk("pins", 8'h01, {7'h00, o_pins_spi});
    chk("master oe", 8'h01, {7'h00, o_sck_oe});
    wr(spi_master_pkg::OFF_DATA, 8'h11);
    repeat (8) @(posedge i_mclk);
    chk("unarmed write", 8'h01, {7'h00, o_ss_n});
    send(8'hA5);
    poll(spi_master_pkg::ST_RXF, d);
    chk("match flag", 8'h01, {7'h00, d[spi_master_pkg::ST_MTCH]});
    rd(spi_master_pkg::OFF_DATA, d);
    chk("rx byte", 8'h3C, d);
    chk("slave rx", 8'hA5, rx);
    chk("frame length", 8'h44, ss_low[7:0]);
    reply = 8'h55;
    send(8'h0F);
    send(8'hF0);
    wait_count(2);
    reply = 8'h66;
    wait_count(3);
    chk("slave rx 2", 8'hF0, rx);
    rd(spi_master_pkg::OFF_DATA, d);
    chk("overrun keep", 8'h55, d);
    send(8'h77);
    for (i = 0; i < 100 && o_ss_n !== 1'b0; i++) @(posedge i_mclk);
    repeat (12) @(posedge i_mclk);
    wr(spi_master_pkg::OFF_BAUD, 8'h03);
    for (i = 0; i < 100 && o_ss_n !== 1'b1; i++) @(posedge i_mclk);
    repeat (40) @(posedge i_mclk);
    rd(spi_master_pkg::OFF_STATUS, d);
    chk("abort rxf", 8'h00, {7'h00, d[spi_master_pkg::ST_RXF]});
    chk("abort frames", 8'h03, cnt[7:0]);
    wr(spi_master_pkg::OFF_CTRL1, 8'h58);
    repeat (4) @(posedge i_mclk);
    chk("idle polarity", 8'h01, {7'h00, o_sck});
    wr(spi_master_pkg::OFF_CTRL1, 8'hD0);
    ss_drv <= 1'b0;
    repeat (8) @(posedge i_mclk);
    chk("fault oe", 8'h00, {6'h00, o_sck_oe, o_mosi_oe});
    chk("fault irq", 8'h01, {7'h00, o_irq});
    rd(spi_master_pkg::OFF_STATUS, d);
    chk("fault flag", 8'h01, {7'h00, d[spi_master_pkg::ST_MODE_FAULT_FLAG]});
    ss_drv <= 1'b1;
    wr(spi_master_pkg::OFF_CTRL1, 8'hC0);
    #1 chk("irq cleared", 8'h00, {7'h00, o_irq});
    rd(spi_master_pkg::OFF_STATUS, d);
    chk("flag cleared", 8'h00, {7'h00, d[spi_master_pkg::ST_MODE_FAULT_FLAG]});
    conclude();
  end
endmodule : spi_master_core_bench
`default_nettype wire
